// *** acc_conv_model.sv ***
// converter core stand-in returning one code per conversion
`timescale 1ns/1ns
`default_nettype none
module acc_conv_model #(
	parameter int CONV_CYCLES = 4
) (
	input  wire logic       mclk,
	input  wire logic       conv_start,
	input  wire logic [4:0] input_selector,
	output logic      [9:0] conv_result
);
	int hold_r;
	// ten-bit code
	// code held through the conversion, then scrambled every cycle
	always_ff @(posedge mclk) begin
		if (conv_start) begin
			conv_result <= {input_selector, 5'h15};
			hold_r <= CONV_CYCLES;
		end else if (hold_r > 0) begin
			hold_r <= hold_r - 1;
		end else begin
			conv_result <= ~conv_result;
		end
	end
endmodule
`default_nettype wire

// *** acc_pkg.sv ***
// constants for the converter control block
package acc_pkg;
	localparam logic [4:0] ACC_OFF_CTRL0    = 5'h00;
	localparam logic [4:0] ACC_OFF_CTRL1    = 5'h04;
	localparam logic [4:0] ACC_OFF_RES_HI   = 5'h08;
	localparam logic [4:0] ACC_OFF_RES_LO   = 5'h0C;
	localparam logic [4:0] ACC_OFF_IRQ_STAT = 5'h10;
	localparam logic [4:0] ACC_OFF_IRQ_EN   = 5'h14;
	localparam logic [4:0] ACC_OFF_IRQ_CLR  = 5'h18;
	localparam int ACC_BIT_EN    = 0;
	localparam int ACC_BIT_GO    = 1;
	localparam int ACC_SEL_LSB   = 2;
	localparam int ACC_SEL_MSB   = 6;
	localparam int ACC_BIT_FMT   = 7;
	localparam logic [7:0] ACC_CTRL0_RST = 8'h00;
	localparam logic [7:0] ACC_CTRL0_MASK = 8'h7F;
	localparam logic [7:0] ACC_CTRL1_RST = 8'h00;
	localparam logic [4:0] ACC_SEL_EXT_MAX = 5'h07;
	localparam logic [4:0] ACC_SEL_EXT10 = 5'h0A;
	localparam logic [4:0] ACC_SEL_TEMP  = 5'h1D;
	localparam logic [4:0] ACC_SEL_DAC   = 5'h1E;
	localparam logic [4:0] ACC_SEL_REFBUF = 5'h1F;
	localparam int ACC_CONV_CYCLES = 22;
	localparam logic [1:0] ACC_RESP_OKAY   = 2'b00;
	localparam logic [1:0] ACC_RESP_SLVERR = 2'b10;
endpackage

// *** acc_top.sv ***
// converter control register block with axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
module acc_top
	import acc_pkg::*;
#(
	parameter int CONV_CYCLES = ACC_CONV_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             converter_enable,
	output logic [4:0]       input_selector,
	output logic [7:0]       ext_input_onehot,
	output logic             ext_input_ten_sel,
	output logic             temp_sel,
	output logic             dac_sel,
	output logic             ref_buf_sel,
	output logic             source_connected,
	output logic             conv_start,
	input  wire logic [9:0]  conv_result,
	output logic             irq
);
	logic [7:0]  ctrl0_r;
	logic [7:0]  ctrl1_r;
	logic [9:0]  result_r;
	logic        busy_r;
	logic [15:0] cnt_r;
	logic        done_stat_r;
	logic        done_en_r;
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [4:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic        wstrb0_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	// write channel handshakes, address and data taken in either order
	wire logic aw_take = s_axi_awvalid & ~aw_hold_r & ~bvalid_r;
	wire logic w_take  = s_axi_wvalid & ~w_hold_r & ~bvalid_r;
	wire logic aw_have = aw_hold_r | aw_take;
	wire logic w_have  = w_hold_r | w_take;
	wire logic wr_fire = aw_have & w_have & ~bvalid_r;
	wire logic [4:0]  wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
	wire logic [31:0] wr_data = w_hold_r ? wdata_r : s_axi_wdata;
	wire logic        wr_lane0 = w_hold_r ? wstrb0_r : s_axi_wstrb[0];
	wire logic wr_ctrl0 = wr_fire & wr_lane0 & (wr_addr == ACC_OFF_CTRL0);
	wire logic wr_ctrl1 = wr_fire & wr_lane0 & (wr_addr == ACC_OFF_CTRL1);
	wire logic wr_ien   = wr_fire & wr_lane0 & (wr_addr == ACC_OFF_IRQ_EN);
	wire logic wr_iclr  = wr_fire & wr_lane0 & (wr_addr == ACC_OFF_IRQ_CLR);
	wire logic wr_known = (wr_addr == ACC_OFF_CTRL0)
		| (wr_addr == ACC_OFF_CTRL1) | (wr_addr == ACC_OFF_IRQ_EN)
		| (wr_addr == ACC_OFF_IRQ_CLR);
	assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
	assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	// conversion sequencing
	wire logic [7:0] wr_byte = wr_data[7:0];
	wire logic start = wr_ctrl0 & wr_byte[ACC_BIT_GO] & wr_byte[ACC_BIT_EN]
		& ~busy_r;
	wire logic finish = busy_r & (cnt_r == 16'(CONV_CYCLES - 1));
	wire logic abort = busy_r & wr_ctrl0 & ~wr_byte[ACC_BIT_EN];

	// bit seven masked off, selector field kept
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl0_r <= ACC_CTRL0_RST;
		end else if (wr_ctrl0) begin
			ctrl0_r <= wr_byte & ACC_CTRL0_MASK;
		end
	end

	// format and other options held for software
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl1_r <= ACC_CTRL1_RST;
		end else if (wr_ctrl1) begin
			ctrl1_r <= wr_byte;
		end
	end

	// busy while converting, idle reads zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			cnt_r  <= 16'h0000;
		end else if (start) begin
			busy_r <= 1'b1;
			cnt_r  <= 16'h0000;
		end else if (finish | abort) begin
			busy_r <= 1'b0;
		end else if (busy_r) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// capture ten-bit result as status sets
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			result_r <= 10'h000;
		end else if (finish & ~abort) begin
			result_r <= conv_result;
		end
	end

	// sticky done flag, set wins over clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			done_stat_r <= 1'b0;
			done_en_r   <= 1'b0;
		end else begin
			if (finish & ~abort) begin
				done_stat_r <= 1'b1;
			end else if (wr_iclr & wr_byte[0]) begin
				done_stat_r <= 1'b0;
			end
			if (wr_ien) begin
				done_en_r <= wr_byte[0];
			end
		end
	end

	// write holding and response
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= 5'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb0_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= ACC_RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_known ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_hold_r <= 1'b1;
					awaddr_r  <= s_axi_awaddr;
				end
				if (w_take) begin
					w_hold_r <= 1'b1;
					wdata_r  <= s_axi_wdata;
					wstrb0_r <= s_axi_wstrb[0];
				end
				if (bvalid_r & s_axi_bready) begin
					bvalid_r <= 1'b0;
				end
			end
		end
	end

	// read decode, status bit shows live conversion state
	wire logic [7:0] ctrl0_view = {1'b0, ctrl0_r[ACC_SEL_MSB:ACC_SEL_LSB],
		busy_r, ctrl0_r[ACC_BIT_EN]};
	// result justification follows the format bit
	wire logic [15:0] res_just = ctrl1_r[ACC_BIT_FMT] ?
		{6'h00, result_r} : {result_r, 6'h00};
	wire logic rd_take = s_axi_arvalid & ~rvalid_r;
	logic [7:0] rd_byte;
	logic       rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			ACC_OFF_CTRL0:    rd_byte = ctrl0_view;
			ACC_OFF_CTRL1:    rd_byte = ctrl1_r;
			ACC_OFF_RES_HI:   rd_byte = res_just[15:8];
			ACC_OFF_RES_LO:   rd_byte = res_just[7:0];
			ACC_OFF_IRQ_STAT: rd_byte = {7'h00, done_stat_r};
			ACC_OFF_IRQ_EN:   rd_byte = {7'h00, done_en_r};
			default: begin
				rd_byte = 8'h00;
				rd_ok   = 1'b0;
			end
		endcase
	end
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// read answer register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= ACC_RESP_OKAY;
		end else if (rd_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= {24'h000000, rd_byte};
			rresp_r  <= rd_ok ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
		end else if (rvalid_r & s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign converter_enable = ctrl0_r[ACC_BIT_EN];
	assign input_selector   = ctrl0_r[ACC_SEL_MSB:ACC_SEL_LSB];
	assign conv_start       = start;
	assign irq              = done_stat_r & done_en_r;

	// external input routing, one line per input
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_ext
			assign ext_input_onehot[gi] = converter_enable
				& (input_selector == 5'(gi));
		end
	endgenerate
	assign ext_input_ten_sel = converter_enable
		& (input_selector == ACC_SEL_EXT10);
	assign temp_sel    = converter_enable & (input_selector == ACC_SEL_TEMP);
	assign dac_sel     = converter_enable & (input_selector == ACC_SEL_DAC);
	assign ref_buf_sel = converter_enable & (input_selector == ACC_SEL_REFBUF);
	assign source_connected = (|ext_input_onehot) | ext_input_ten_sel
		| temp_sel | dac_sel | ref_buf_sel;
endmodule
`default_nettype wire

// *** acc_top_props.sv ***
// assertion checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module acc_top_props
	import acc_pkg::*;
#(
	parameter int CONV_CYCLES = ACC_CONV_CYCLES
) (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        converter_enable,
	input wire logic [4:0]  input_selector,
	input wire logic [7:0]  ext_input_onehot,
	input wire logic        ext_input_ten_sel,
	input wire logic        temp_sel,
	input wire logic        dac_sel,
	input wire logic        ref_buf_sel,
	input wire logic        source_connected,
	input wire logic        conv_start
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// source routing follows enable and selector code
	a_ext_route: assert property (ext_input_onehot == (converter_enable
		&& input_selector <= 5'h07 ? 8'h01 << input_selector : 8'h00))
		else $error("external route wrong");
	a_ten_route: assert property (ext_input_ten_sel ==
		(converter_enable && input_selector == 5'h0A))
		else $error("input ten route wrong");
	a_src_conn: assert property (source_connected == (converter_enable &&
		(input_selector <= 5'h07 || input_selector == 5'h0A
		|| input_selector >= 5'h1D))) else $error("reserved code connects");
	a_internal_src: assert property ({temp_sel, dac_sel, ref_buf_sel} ==
		(converter_enable ? {input_selector == 5'h1D, input_selector == 5'h1E,
		input_selector == 5'h1F} : 3'h0)) else $error("internal route wrong");
	a_start_enabled: assert property (conv_start |=> converter_enable)
		else $error("start while disabled");
	a_start_gap: assert property (conv_start |=> !conv_start [*2])
		else $error("restart while busy");
	a_rdata_upper: assert property (s_axi_rvalid |->
		s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
endmodule
bind acc_top acc_top_props #(.CONV_CYCLES(CONV_CYCLES)) i_acc_top_props (.*);
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import acc_pkg::*;
	localparam int CONV_CYCLES = 8;
	logic        mclk = 1'b0, rst_n = 1'b0;
	logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00, input_selector;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, converter_enable, conv_start, irq, temp_sel;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  ext_input_onehot;
	logic        ext_input_ten_sel, dac_sel, ref_buf_sel, source_connected;
	logic [9:0]  conv_result;
	int          fail_count = 0, samples_checked = 0, cycles = 0, starts = 0;

	acc_top #(.CONV_CYCLES(CONV_CYCLES)) i_acc_top (.*);
	acc_conv_model #(.CONV_CYCLES(CONV_CYCLES)) i_acc_conv_model (.*);

	initial forever #25 mclk = ~mclk;
	// start pulse count and hang ceiling
	always @(posedge mclk) begin
		cycles++;
		starts += int'(conv_start);
		if (cycles == 3000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic summarize;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bus write: address and data offered together, each dropped when taken
	task automatic wr(input logic [4:0] a, input logic [7:0] d,
		input logic [1:0] r);
		bit aw = 1'b0;
		bit w = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge mclk);
			aw = aw | (s_axi_awvalid & s_axi_awready);
			w = w | (s_axi_wvalid & s_axi_wready);
			s_axi_awvalid <= ~aw;
			s_axi_wvalid <= ~w;
		end
		do @(posedge mclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(r));
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] d,
		input logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, {24'h0, d});
		chk(32'(s_axi_rresp), 32'(r));
	endtask
	task automatic t_select;
		logic [12:0] e;
		rd(ACC_OFF_CTRL0, 8'h00, ACC_RESP_OKAY);
		rd(ACC_OFF_CTRL1, 8'h00, ACC_RESP_OKAY);
		for (int c = 0; c < 32; c++) begin
			wr(ACC_OFF_CTRL0, {1'b0, 5'(c), 2'b01}, ACC_RESP_OKAY);
			rd(ACC_OFF_CTRL0, {1'b0, 5'(c), 2'b01}, ACC_RESP_OKAY);
			e = {8'(c < 8 ? 1 << c : 0), c == 10, c == 29, c == 30, c == 31, 1'b0};
			e[0] = |e[12:1];
			chk(32'({ext_input_onehot, ext_input_ten_sel, temp_sel, dac_sel,
				ref_buf_sel, source_connected}), 32'(e));
		end
		wr(ACC_OFF_CTRL0, 8'h7C, ACC_RESP_OKAY);
		chk(32'({ref_buf_sel, source_connected}), 32'h0);
		wr(ACC_OFF_CTRL0, 8'hFD, ACC_RESP_OKAY);
		rd(ACC_OFF_CTRL0, 8'h7D, ACC_RESP_OKAY);
		wr(5'h1C, 8'h01, ACC_RESP_SLVERR);
		rd(5'h1C, 8'h00, ACC_RESP_SLVERR);
	endtask
	task automatic t_convert;
		wr(ACC_OFF_IRQ_EN, 8'h01, ACC_RESP_OKAY);
		wr(ACC_OFF_CTRL0, 8'h29, ACC_RESP_OKAY);
		wr(ACC_OFF_CTRL0, 8'h2B, ACC_RESP_OKAY);
		chk(32'(starts), 32'h1);
		rd(ACC_OFF_CTRL0, 8'h2B, ACC_RESP_OKAY);
		for (int n = 0; n < 40 && irq !== 1'b1; n++) @(posedge mclk);
		chk(32'(irq), 32'h1);
		rd(ACC_OFF_CTRL0, 8'h29, ACC_RESP_OKAY);
		rd(ACC_OFF_RES_HI, 8'h55, ACC_RESP_OKAY);
		rd(ACC_OFF_RES_LO, 8'h40, ACC_RESP_OKAY);
		wr(ACC_OFF_IRQ_EN, 8'h00, ACC_RESP_OKAY);
		chk(32'(irq), 32'h0);
		rd(ACC_OFF_IRQ_STAT, 8'h01, ACC_RESP_OKAY);
		wr(ACC_OFF_IRQ_EN, 8'h01, ACC_RESP_OKAY);
		wr(ACC_OFF_IRQ_CLR, 8'h01, ACC_RESP_OKAY);
		chk(32'(irq), 32'h0);
		wr(ACC_OFF_CTRL0, 8'h2A, ACC_RESP_OKAY);
		chk(32'(starts), 32'h1);
	endtask
	// right justified result, masked write lane, abort by disable
	task automatic t_misc;
		wr(ACC_OFF_CTRL1, 8'h80, ACC_RESP_OKAY);
		rd(ACC_OFF_RES_HI, 8'h01, ACC_RESP_OKAY);
		rd(ACC_OFF_RES_LO, 8'h55, ACC_RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		wr(ACC_OFF_CTRL1, 8'h00, ACC_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(ACC_OFF_CTRL1, 8'h80, ACC_RESP_OKAY);
		wr(ACC_OFF_CTRL0, 8'h2B, ACC_RESP_OKAY);
		chk(32'(starts), 32'h2);
		wr(ACC_OFF_CTRL0, 8'h28, ACC_RESP_OKAY);
		repeat (20) @(posedge mclk);
		rd(ACC_OFF_CTRL0, 8'h28, ACC_RESP_OKAY);
		rd(ACC_OFF_IRQ_STAT, 8'h00, ACC_RESP_OKAY);
		chk(32'(irq), 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		t_select();
		t_convert();
		t_misc();
		summarize();
	end
endmodule
`default_nettype wire
